// ---- hw/gcs_cmd_status.sv ----
// Command line holding, emulation parser, status queue and serial poll.
// Assumes decoded commands and raw bus characters arrive synchronously.
`timescale 1ns/1ps
`default_nettype none
module gcs_cmd_status
  import gcs_pkg::*;
#(
  parameter int QDEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             rx_valid,
  input  wire logic [7:0]       rx_data,
  input  wire logic             cmd_valid,
  input  wire logic [CLS_W-1:0] cmd_class,
  input  wire logic [ARG_W-1:0] cmd_arg,
  input  wire logic             ren,
  input  wire logic             spoll_rd,
  input  wire logic             data_rd,
  input  wire logic             sw_changed,
  input  wire logic             det_change,
  input  wire logic             recal_done,
  input  wire logic             det_restored,
  input  wire logic             over_range,
  input  wire logic             under_range,
  input  wire logic             collecting,
  input  wire logic             autoscale_done,
  input  wire logic             output_ready,
  input  wire logic [19:0]      meas_mant,
  input  wire logic [7:0]       meas_exp,
  output logic                  exec_valid,
  output logic      [CLS_W-1:0] exec_class,
  output logic      [ARG_W-1:0] exec_arg,
  output logic                  srq,
  output logic      [7:0]       spoll_byte,
  output logic                  talk_valid,
  output logic      [7:0]       talk_byte,
  output logic                  bus_locked,
  output logic                  ur_display,
  output logic      [19:0]      out_mant,
  output logic      [7:0]       out_exp
);
  localparam int NCLS = 1 << CLS_W;
  localparam logic [4:0] QFULL = 5'(QDEPTH);

  logic [2:0]       ctrl_r;
  logic             srq_en_r, lock_r, boot_r, ren_q_r, ur_q_r, last_cr_r;
  logic [NCLS-1:0]  pend_v_r, run_v_r, pv_nxt;
  logic [ARG_W-1:0] pend_arg_r [NCLS];
  logic [ARG_W-1:0] run_arg_r  [NCLS];
  logic [ARG_W-1:0] pa_nxt     [NCLS];
  logic             walk_r, term_hold_r;
  logic [CLS_W-1:0] widx_r;
  gcs_em_t          em_r;
  logic [1:0]       ndig_r;
  logic [9:0]       acc_r;
  logic             gt_r, emok_r;
  logic [CLS_W-1:0] emcls_r;
  logic [ARG_W-1:0] cdly_r;
  logic [5:0]       q_r [QDEPTH];
  logic [3:0]       wptr_r, rptr_r;
  logic [4:0]       cnt_r;
  logic [EV_N-1:0]  ev_pend_r, ev_in;
  logic             outrdy_r;
  logic [5:0]       cur_cond_r, head;

  wire emul      = ctrl_r[CTRL_EMUL];
  wire rx_take   = rx_valid && !lock_r;
  wire is_lf     = rx_take && (rx_data == CH_LF);
  wire line_end  = is_lf && (emul || last_cr_r);
  wire commit    = (line_end || term_hold_r) && !walk_r;
  wire emu_valid = emok_r || (em_r == EM_DIG && ndig_r != 2'h0);
  wire emu_wr    = line_end && emul && emu_valid;
  wire nat_wr    = cmd_valid && !lock_r && !emul;
  wire wr_v      = nat_wr || emu_wr;
  wire ren_fall  = ren_q_r && !ren;
  wire ur_rise   = under_range && !ur_q_r;
  wire pop       = spoll_rd && cnt_r != 5'h00;
  wire [CLS_W-1:0] wr_cls = emu_wr ? emcls_r : cmd_class;
  wire [ARG_W-1:0] emu_arg = (emcls_r == CLS_UPDATE) ? ARG_W'(0) :
                             ARG_W'(acc_r) * (gt_r ? GT_NS : LT_NS);
  wire [ARG_W-1:0] wr_arg = emu_wr ? emu_arg : cmd_arg;
  wire [3:0]       dig    = 4'(rx_data - CH_0);
  wire             is_dig = rx_data >= CH_0 && rx_data <= CH_9;

  // ----------------------------------------------------------------
  // Line holding table
  // ----------------------------------------------------------------
  // later overrides
  always_comb begin
    pv_nxt = pend_v_r;
    pa_nxt = pend_arg_r;
    if (wr_v) begin
      pv_nxt[wr_cls] = 1'b1;
      pa_nxt[wr_cls] = wr_arg;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pend_v_r <= '0;
      run_v_r  <= '0;
      for (int i = 0; i < NCLS; i++) begin
        pend_arg_r[i] <= '0;
        run_arg_r[i]  <= '0;
      end
    end else if (commit) begin
      pend_v_r  <= '0;
      run_v_r   <= pv_nxt;
      run_arg_r <= pa_nxt;
    end else begin
      pend_v_r   <= pv_nxt;
      pend_arg_r <= pa_nxt;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      last_cr_r   <= 1'b0;
      term_hold_r <= 1'b0;
    end else begin
      if (rx_take) begin
        last_cr_r <= (rx_data == CH_CR);
      end
      term_hold_r <= line_end && walk_r ? 1'b1 : (commit ? 1'b0 : term_hold_r);
    end
  end

  // ----------------------------------------------------------------
  // Execution walk over the committed table
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      walk_r     <= 1'b0;
      widx_r     <= '0;
      exec_valid <= 1'b0;
      exec_class <= '0;
      exec_arg   <= '0;
    end else begin
      exec_valid <= walk_r && run_v_r[widx_r];
      exec_class <= widx_r;
      exec_arg   <= run_arg_r[widx_r];
      if (commit) begin
        walk_r <= 1'b1;
        widx_r <= '0;
      end else if (walk_r) begin
        widx_r <= widx_r + 1'b1;
        walk_r <= widx_r != CLS_W'(NCLS - 1);
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      srq_en_r <= 1'b1;
      cdly_r   <= '0;
    end else if (exec_valid && exec_class == CLS_SRQ) begin
      srq_en_r <= exec_arg[0];
    end else if (exec_valid && exec_class == CLS_CDLY) begin
      cdly_r <= exec_arg;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      talk_valid <= 1'b0;
      talk_byte  <= 8'h00;
    end else begin
      talk_valid <= exec_valid && exec_class == CLS_QUERY;
      if (exec_valid && exec_class == CLS_QUERY) begin
        talk_byte <= {2'b00, cur_cond_r};
      end
    end
  end

  // ----------------------------------------------------------------
  // Emulation string parser
  // ----------------------------------------------------------------
  // first command only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      em_r    <= EM_START;
      ndig_r  <= 2'h0;
      acc_r   <= 10'h000;
      gt_r    <= 1'b0;
      emok_r  <= 1'b0;
      emcls_r <= CLS_UPDATE;
    end else if (rx_take && emul) begin
      if (rx_data == CH_LF) begin
        em_r   <= EM_START;
        emok_r <= 1'b0;
      end else begin
        unique case (em_r)
          EM_START: begin
            if (rx_data == CH_QM) begin
              emcls_r <= CLS_UPDATE;
              emok_r  <= 1'b1;
              em_r    <= EM_SKIP;
            end else if (rx_data == CH_LT || rx_data == CH_GT) begin
              emcls_r <= CLS_CDLY;
              gt_r    <= rx_data == CH_GT;
              acc_r   <= 10'h000;
              ndig_r  <= 2'h0;
              em_r    <= EM_DIG;
            end else if (rx_data != CH_CR) begin
              em_r <= EM_SKIP;
            end
          end
          EM_DIG: begin
            if (is_dig && ndig_r != EMU_MAXD) begin
              acc_r  <= 10'(acc_r * EMU_BASE + 10'(dig));
              ndig_r <= ndig_r + 1'b1;
            end else begin
              emok_r <= ndig_r != 2'h0;
              em_r   <= EM_SKIP;
            end
          end
          EM_SKIP: begin
            em_r <= EM_SKIP;
          end
          default: em_r <= EM_SKIP;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Condition detection
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      boot_r  <= 1'b0;
      ren_q_r <= 1'b0;
      ur_q_r  <= 1'b0;
    end else begin
      boot_r  <= 1'b1;
      ren_q_r <= ren;
      ur_q_r  <= under_range;
    end
  end

  always_comb begin
    ev_in           = '0;
    ev_in[EV_SW]    = !boot_r && sw_changed;
    ev_in[EV_DET]   = det_change;
    ev_in[EV_OVER]  = over_range;
    ev_in[EV_UNDER] = ur_rise && collecting;
    ev_in[EV_AUTO]  = autoscale_done;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lock_r <= 1'b0;
    end else if (det_change) begin
      lock_r <= 1'b1;
    end else if (recal_done || det_restored) begin
      lock_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ur_display <= 1'b0;
    end else begin
      ur_display <= under_range;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      out_mant <= 20'h00000;
      out_exp  <= 8'h00;
    end else if (under_range) begin
      out_mant <= ctrl_r[CTRL_LOG] ? LOG_MARK : LIN_MANT;
      out_exp  <= ctrl_r[CTRL_LOG] ? LOG_EXP : LIN_EXP;
    end else begin
      out_mant <= meas_mant;
      out_exp  <= meas_exp;
    end
  end

  // ----------------------------------------------------------------
  // Status queue
  // ----------------------------------------------------------------
  logic       pick_v;
  logic [2:0] pick_i;
  always_comb begin
    pick_v = 1'b0;
    pick_i = 3'h0;
    for (int i = EV_N - 1; i >= 0; i--) begin
      if (ev_pend_r[i]) begin
        pick_v = 1'b1;
        pick_i = 3'(i);
      end
    end
  end
  wire push = pick_v && srq_en_r && cnt_r != QFULL && !ren_fall;

  genvar g;
  generate
    for (g = 0; g < EV_N; g++) begin : g_ev
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          ev_pend_r[g] <= 1'b0;
        end else begin
          ev_pend_r[g] <= ev_in[g] || (ev_pend_r[g] && srq_en_r && !ren_fall &&
                          !(push && pick_i == 3'(g)));
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wptr_r <= 4'h0;
      rptr_r <= 4'h0;
      cnt_r  <= 5'h00;
      for (int i = 0; i < QDEPTH; i++) begin
        q_r[i] <= CODE_NONE;
      end
    end else if (ren_fall) begin
      wptr_r <= 4'h0;
      rptr_r <= 4'h0;
      cnt_r  <= 5'h00;
    end else begin
      if (push) begin
        q_r[wptr_r] <= gcs_ev_code(int'(pick_i));
        wptr_r      <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      cnt_r <= cnt_r + 5'(push) - 5'(pop);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      outrdy_r <= 1'b0;
    end else if (output_ready && srq_en_r) begin
      outrdy_r <= 1'b1;
    end else if (data_rd || ren_fall || (spoll_rd && head == CODE_OUTRDY)) begin
      outrdy_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cur_cond_r <= CODE_NONE;
    end else if (pick_v) begin
      cur_cond_r <= gcs_ev_code(int'(pick_i));
    end else if (output_ready) begin
      cur_cond_r <= CODE_OUTRDY;
    end else if (ren_fall || talk_valid) begin
      cur_cond_r <= CODE_NONE;
    end
  end

  // queued codes first
  // Output-ready stays hidden while an event is still on its way into the queue.
  assign head = cnt_r != 5'h00 ? q_r[rptr_r] :
                ((outrdy_r && !pick_v) ? CODE_OUTRDY : CODE_NONE);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      srq        <= 1'b0;
      spoll_byte <= 8'h00;
    end else begin
      srq        <= srq_en_r && head != CODE_NONE;
      spoll_byte <= {1'b0, srq_en_r && head != CODE_NONE, head};
    end
  end

  assign bus_locked = lock_r;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire apb_setup = psel && !penable && !pready;
  wire apb_wr    = psel && penable && pready && pwrite;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (apb_setup) begin
        unique case (paddr)
          OFF_CTRL:  prdata <= 32'(ctrl_r);
          OFF_STAT: begin
            prdata[ST_SRQEN]          <= srq_en_r;
            prdata[ST_SRQ]            <= srq;
            prdata[ST_LOCK]           <= lock_r;
            prdata[ST_ORDY]           <= outrdy_r;
            prdata[ST_CNT +: 5]       <= cnt_r;
            prdata[ST_HEAD +: 6]      <= head;
          end
          OFF_CDLY:  prdata <= 32'(cdly_r);
          OFF_SPOLL: prdata <= 32'(spoll_byte);
          default:   pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_r <= CTRL_RST;
    end else if (apb_wr && paddr == OFF_CTRL) begin
      ctrl_r <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_line_done;
    line_end || term_hold_r;
  endsequence
  sequence s_pop_more;
    spoll_rd && cnt_r > 5'h01 && srq_en_r && !exec_valid && !ren_fall;
  endsequence

  a_walk_after_term: assert property ($rose(walk_r) |-> $past(line_end || term_hold_r))
    else $error("execution started without a line terminator");
  a_later_wins: assert property ((wr_v && !commit) |=>
      pend_v_r[$past(wr_cls)] && pend_arg_r[$past(wr_cls)] == $past(wr_arg))
    else $error("later command did not replace earlier one");
  a_srq_enable_cmd: assert property ((exec_valid && exec_class == CLS_SRQ) |=>
      srq_en_r == $past(exec_arg[0]))
    else $error("request enable command not applied");
  a_ren_clears: assert property ((ren_fall && !output_ready) |=> cnt_r == 5'h00 && !outrdy_r)
    else $error("remote enable drop did not clear status");
  a_data_rd_clear: assert property ((data_rd && !output_ready) |=> !outrdy_r)
    else $error("output ready not cleared by data read");
  a_no_queue_off: assert property (!srq_en_r |=> cnt_r <= $past(cnt_r))
    else $error("status queued while requests disabled");
  a_next_value: assert property (s_pop_more |=> ##1 spoll_byte[SPB_RQS] && srq)
    else $error("request dropped with values still queued");
  a_rqs_bit: assert property (spoll_byte[SPB_RQS] |-> srq && $past(srq_en_r))
    else $error("request bit set without enabled request");
  a_query_bit: assert property (talk_valid |-> talk_byte[7:6] == 2'b00)
    else $error("status query byte has request bit set");
  a_det_lock: assert property (det_change |=> lock_r [*2] or (lock_r ##1 !lock_r))
    else $error("detector change did not lock bus data");
  a_ur_marker: assert property ((under_range && ctrl_r[CTRL_LOG]) |=> out_mant == LOG_MARK)
    else $error("under-range log marker missing");
  a_emu_skip: assert property ((em_r == EM_SKIP && rx_take && rx_data != CH_LF) |=>
      em_r == EM_SKIP)
    else $error("emulation parser left skip before line end");
  a_commit_once: assert property (commit |=> walk_r ##1 walk_r)
    else $error("committed line was not executed");
endmodule // gcs_cmd_status
`default_nettype wire

// ---- pkg/gcs_pkg.sv ----
// Constants, types and helpers shared by the command and status logic.
// Assumes a single 10 MHz clock domain and an APB register port.
`default_nettype none
package gcs_pkg;
  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_STAT  = 8'h04;
  localparam logic [7:0] OFF_CDLY  = 8'h08;
  localparam logic [7:0] OFF_SPOLL = 8'h0c;
  localparam int CTRL_EMUL = 0;
  localparam int CTRL_TRIG = 1;
  localparam int CTRL_LOG  = 2;
  localparam logic [2:0] CTRL_RST = 3'h6;
  localparam int ST_SRQEN = 0;
  localparam int ST_SRQ   = 1;
  localparam int ST_LOCK  = 2;
  localparam int ST_ORDY  = 3;
  localparam int ST_CNT   = 8;
  localparam int ST_HEAD  = 16;
  // ----------------------------------------------------------------
  // Characters, command classes and status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_QM = 8'h3f;
  localparam logic [7:0] CH_LT = 8'h3c;
  localparam logic [7:0] CH_GT = 8'h3e;
  localparam logic [7:0] CH_0  = 8'h30;
  localparam logic [7:0] CH_9  = 8'h39;
  localparam int CLS_W = 4;
  localparam int ARG_W = 20;
  localparam logic [3:0] CLS_UPDATE = 4'h1;
  localparam logic [3:0] CLS_SRQ    = 4'h2;
  localparam logic [3:0] CLS_QUERY  = 4'h3;
  localparam logic [3:0] CLS_CDLY   = 4'h4;
  localparam logic [5:0] CODE_NONE   = 6'h00;
  localparam logic [5:0] CODE_OUTRDY = 6'h01;
  localparam logic [5:0] CODE_AUTO   = 6'h1b;
  localparam logic [5:0] CODE_SW     = 6'h20;
  localparam logic [5:0] CODE_DET    = 6'h21;
  localparam logic [5:0] CODE_OVER   = 6'h22;
  localparam logic [5:0] CODE_UNDER  = 6'h23;
  localparam int SPB_RQS = 6;
  localparam int EV_SW = 0;
  localparam int EV_DET = 1;
  localparam int EV_OVER = 2;
  localparam int EV_UNDER = 3;
  localparam int EV_AUTO = 4;
  localparam int EV_N = 5;
  // ----------------------------------------------------------------
  // Emulation scaling and data markers
  // ----------------------------------------------------------------
  localparam logic [9:0]  EMU_BASE  = 10'h00a;
  localparam logic [1:0]  EMU_MAXD  = 2'h3;
  localparam logic [19:0] LT_NS     = 20'h0000a;
  localparam logic [19:0] GT_NS     = 20'h00064;
  localparam logic [19:0] LOG_MARK  = 20'he7961;
  localparam logic [7:0]  LOG_EXP   = 8'h00;
  localparam logic [19:0] LIN_MANT  = 20'h00000;
  localparam logic [7:0]  LIN_EXP   = 8'h9d;

  typedef enum logic [1:0] {
    EM_START = 2'b00,
    EM_DIG   = 2'b01,
    EM_SKIP  = 2'b10
  } gcs_em_t;

  function automatic logic [5:0] gcs_ev_code(input int idx);
    unique case (idx)
      EV_SW:    return CODE_SW;
      EV_DET:   return CODE_DET;
      EV_OVER:  return CODE_OVER;
      EV_UNDER: return CODE_UNDER;
      default:  return CODE_AUTO;
    endcase
  endfunction
endpackage
`default_nettype wire

// ---- verif/gcs_ctl_model.sv ----
// Bus controller model: serial-polls the device while it requests service.
// Assumes the status byte settles two cycles after each poll pulse.
`timescale 1ns/1ps
`default_nettype none
module gcs_ctl_model (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       poll_en,
  input  wire logic       srq,
  input  wire logic [7:0] spoll_byte,
  output logic            spoll_rd,
  output logic      [7:0] polls,
  output logic      [5:0] code
);
  logic [1:0] gap;
  // keep polling, strip the request bit
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      spoll_rd <= 1'b0;
      gap <= 2'h0;
      polls <= 8'h00;
      code <= 6'h00;
    end else if (gap != 2'h0) begin
      spoll_rd <= 1'b0;
      gap <= gap - 2'h1;
    end else if (poll_en && srq) begin
      spoll_rd <= 1'b1;
      gap <= 2'h3;
      polls <= polls + 8'h01;
      code <= spoll_byte[5:0];
    end
  end
endmodule // gcs_ctl_model
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench for the command and status logic.
// Assumes a 100 ns clock and the controller model on the poll side.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gcs_pkg::*;
  typedef struct {logic [6:0] m; logic c; logic [7:0] e;} gcs_row_t;
  typedef struct {string s; int n; logic [3:0] c; logic [19:0] a;} gcs_emu_t;
  logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, rx_valid = 0;
  logic cmd_valid = 0, ren = 1, sw = 1, col = 0, poll_en = 0, er, drs = 0;
  logic pready, pslverr, xv, srq, tv, spoll_rd, lock, urd;
  logic [7:0] paddr = 8'h00, rx_data = 8'h00, sp, tk, tb_t, oe;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] cmd_class = 4'h0, xc, lcls;
  logic [19:0] cmd_arg = 20'h0, xa, larg, om;
  logic [6:0] ev = 7'h00;
  logic [5:0] pcode;
  int failures = 0, samples_checked = 0, nexec = 0, cyc = 0, n0;
  gcs_row_t rows[4] = '{'{7'h02, 0, 8'h62}, '{7'h04, 0, 8'h5b},
                        '{7'h18, 1, 8'h63}, '{7'h10, 0, 8'h00}};
  gcs_emu_t emu[4] = '{'{"<12\r\n", 1, CLS_CDLY, 20'd12 * LT_NS},
                       '{">999\r\n", 1, CLS_CDLY, 20'd999 * GT_NS},
                       '{"?<5\r\n", 1, CLS_UPDATE, 20'h0}, '{"x?\r\n", 0, 4'h0, 20'h0}};
  always #50 clock = ~clock;
  gcs_cmd_status dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .cmd_valid(cmd_valid),
    .cmd_class(cmd_class), .cmd_arg(cmd_arg), .ren(ren), .spoll_rd(spoll_rd),
    .data_rd(ev[5]), .sw_changed(sw), .det_change(ev[0]), .recal_done(ev[6]),
    .det_restored(drs), .over_range(ev[1]), .under_range(ev[4]), .collecting(col),
    .autoscale_done(ev[2]), .output_ready(ev[3]), .meas_mant(20'h12345),
    .meas_exp(8'h05), .exec_valid(xv), .exec_class(xc), .exec_arg(xa), .srq(srq),
    .spoll_byte(sp), .talk_valid(tv), .talk_byte(tk), .bus_locked(lock),
    .ur_display(urd), .out_mant(om), .out_exp(oe));
  gcs_ctl_model ctl (.clock(clock), .reset(reset), .poll_en(poll_en), .srq(srq),
    .spoll_byte(sp), .spoll_rd(spoll_rd), .polls(), .code(pcode));
  task automatic end_of_test;
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic pulse(input logic [6:0] m);
    ev <= m; wt(1); ev <= 7'h00; wt(5);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [19:0] a);
    cmd_valid <= 1'b1; cmd_class <= c; cmd_arg <= a; wt(1); cmd_valid <= 1'b0; wt(1);
  endtask
  task automatic send(input string s);
    for (int k = 0; k < s.len(); k++) begin rx_valid <= 1'b1; rx_data <= s[k]; wt(1); end
    rx_valid <= 1'b0; wt(1);
  endtask
  task automatic drain;
    poll_en <= 1'b1; wt(80); poll_en <= 1'b0; wt(2);
    chk(sp, 8'h00);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (xv === 1'b1) begin nexec <= nexec + 1; lcls <= xc; larg <= xa; end
    if (tv === 1'b1) tb_t <= tk;
    if (cyc == 20000) begin failures++; end_of_test; end
  end
  initial begin
    wt(4); reset <= 1'b0; wt(1); sw <= 1'b0; wt(5);
    chk(sp, 8'h60);
    apb(0, OFF_STAT, 0); chk(rd[ST_SRQEN], 1);
    apb(0, OFF_CTRL, 0); chk(rd, 32'h6);
    apb(0, 8'h10, 0); chk(er, 1);
    drain();
    foreach (rows[r]) begin
      col <= rows[r].c; pulse(rows[r].m);
      chk(sp, rows[r].e);
      drain();
    end
    col <= 1'b0; pulse(7'h06); chk(sp, 8'h62);
    poll_en <= 1'b1; wt(1); poll_en <= 1'b0; wt(5);
    chk({srq, sp}, 9'h15b); chk(pcode, CODE_OVER); drain();
    pulse(7'h08); chk(sp, 8'h41); pulse(7'h20); chk(sp, 8'h00);
    pulse(7'h02); ren <= 1'b0; wt(5); chk({srq, sp}, 9'h0); ren <= 1'b1;
    pulse(7'h01); chk(lock, 1); n0 = nexec; cmd(CLS_QUERY, 0); send("\r\n"); wt(25);
    chk(nexec - n0, 0); pulse(7'h40); chk(lock, 0); drain();
    pulse(7'h01); chk(lock, 1); drs <= 1'b1; wt(1); drs <= 1'b0; wt(1); chk(lock, 0);
    drain();
    n0 = nexec; cmd(CLS_SRQ, 1); cmd(CLS_SRQ, 0); send("\r"); wt(3);
    chk(nexec - n0, 0); send("\n"); wt(25);
    chk({nexec - n0, lcls, larg}, {32'd1, CLS_SRQ, 20'h0});
    pulse(7'h02); chk(srq, 0); cmd(CLS_QUERY, 0); send("\r\n"); wt(25);
    chk(tb_t, {2'b00, CODE_OVER});
    cmd(CLS_SRQ, 1); send("\r\n"); wt(25); apb(0, OFF_STAT, 0); chk(rd[ST_SRQEN], 1);
    ev <= 7'h10; wt(3); chk({om, oe}, {LOG_MARK, LOG_EXP}); apb(1, OFF_CTRL, 2); wt(2);
    chk({om, oe}, {LIN_MANT, LIN_EXP}); chk(urd, 1); ev <= 7'h00; wt(3);
    chk({om, oe}, 28'h1234505); chk(urd, 0); drain();
    pulse(7'h02); chk(sp, 8'h62); reset <= 1'b1; wt(2); reset <= 1'b0; wt(2);
    chk({srq, sp}, 9'h000); apb(0, OFF_CTRL, 0); chk(rd, 32'h6);
    apb(1, OFF_CTRL, 7);
    foreach (emu[r]) begin
      n0 = nexec; send(emu[r].s); wt(25);
      chk(nexec - n0, emu[r].n);
      if (emu[r].n > 0) chk({lcls, larg}, {emu[r].c, emu[r].a});
    end
    end_of_test;
  end
endmodule // tb
`default_nettype wire
